//--- hdl/shs_pkg.sv
// Shared constants and types for the strap and serial host bus selection block.
// Assumes a single 50 MHz system clock and a synchronous active-high reset.
package shs_pkg;

	localparam int CLK_PERIOD_NS = 20;

	// One quarter of the I2C host clock period; a least time, so it rounds up.
	localparam int I2C_QTR_NS = 2500;
	localparam int I2C_QTR_CYC = (I2C_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [7:0] I2C_CTRL_RD = 8'hBF;
	localparam logic [7:0] I2C_CTRL_WR = 8'hBE;
	localparam logic [7:0] EEPROM_START_ADDR = 8'h00;

	// Byte positions in the EEPROM load sequence.
	localparam logic [7:0] SEQ_CTRL_WR = 8'h00;
	localparam logic [7:0] SEQ_ADDR = 8'h01;
	localparam logic [7:0] SEQ_CTRL_RD = 8'h02;
	localparam logic [7:0] SEQ_FIRST_DATA = 8'h03;

	localparam int CFG_BYTES_DEF = 16;
	localparam logic [3:0] I2C_LAST_BIT = 4'h8;

	typedef enum logic [1:0] {
		SHS_MODE_I2C_HOST = 2'b00,
		SHS_MODE_I2C_CLIENT = 2'b01,
		SHS_MODE_SPI_CLIENT = 2'b10,
		SHS_MODE_MGMT = 2'b11
	} shs_access_mode_t;

	typedef struct packed {
		logic p1_speed;
		logic p1_autoneg;
		logic p2_hi;
		logic p2_lo;
	} shs_strap_t;

	typedef struct packed {
		logic speed_100;
		logic full_duplex;
		logic link;
		logic activity;
	} shs_port_status_t;

endpackage : shs_pkg

//--- hdl/shs_pin_sync.sv
// Three-stage synchroniser with an agreement filter for pins from outside the clock domain.
// Assumes the pins may change at any time; the filtered level moves only when stages two
// and three agree.
module shs_pin_sync #(
	parameter int WIDTH = 1
) (
	// Clock
	input wire logic clk_sys_i,
	// Pins
	input wire logic [WIDTH-1:0] pin_i,
	// Filtered levels
	output logic [WIDTH-1:0] level_o
);

	logic [WIDTH-1:0] ff1_q;
	logic [WIDTH-1:0] ff2_q;
	logic [WIDTH-1:0] ff3_q;
	logic [WIDTH-1:0] level_q;

	// No reset here: strap levels must flow through while the block is held in reset.
	always_ff @(posedge clk_sys_i) begin
		ff1_q <= pin_i;
		ff2_q <= ff1_q;
		ff3_q <= ff2_q;
	end

	always_ff @(posedge clk_sys_i) begin
		for (int i = 0; i < WIDTH; i++) begin
			if (ff2_q[i] == ff3_q[i]) begin
				level_q[i] <= ff3_q[i];
			end
		end
	end

	assign level_o = level_q;

endmodule : shs_pin_sync

//--- hdl/shs_strap_select.sv
// Strap capture, register-access mode selection, serial client select handling and
// EEPROM loading in I2C host mode.
// Assumes straps are pulled to their levels while reset is held, and that the serial
// client engine behind serial_client_data_i runs elsewhere.

// Operation
// [RL1] While the select input is high the serial data output is floated.
// [RL2] A falling edge on the select input starts a serial client transfer.
// [RL3] With auto-negotiation strapped off, the speed strap forces 100BT when high, 10BT when low.
// [RL4] The auto-negotiation strap enables it when high and disables it when low.
// [RL5] By default the first port 1 indicator shows speed and the second link/activity.
// [RL6] Port 2 indicator straps at [0, 0] select I2C host mode with EEPROM loading.
// [RL7] In I2C host mode an absent EEPROM leaves registers and straps at their defaults.
// [RL8] In I2C host mode the clock pin is driven, data is two-way, serial out floats.
// [RL9] Control byte 1011_1111 marks a read and 1011_1110 a write.
// [RL10] Port 2 indicator straps at [1, 0] select serial client mode.
// [RL11] The management-serial mode gives access to all internal 8-bit registers.
// [RL12] Strap pins are inputs during reset, sampled then, and outputs afterwards.
// [RL13] The outside system drives the active-low hardware reset to reset the device.
module shs_strap_select #(
	parameter int CFG_BYTES = shs_pkg::CFG_BYTES_DEF,
	parameter int QTR_CYC = shs_pkg::I2C_QTR_CYC
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic srst_i,
	// Serial client pins
	input wire logic serial_select_n_i,
	input wire logic serial_client_data_i,
	output logic serial_client_out_o,
	output logic serial_client_out_oe_o,
	output logic transfer_start_o,
	// I2C host pins
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Indicator and strap pins
	input wire logic port1_indicator_hi_i,
	output logic port1_indicator_hi_o,
	output logic port1_indicator_hi_oe_o,
	input wire logic port1_indicator_lo_i,
	output logic port1_indicator_lo_o,
	output logic port1_indicator_lo_oe_o,
	input wire logic port2_indicator_hi_i,
	output logic port2_indicator_hi_o,
	output logic port2_indicator_hi_oe_o,
	input wire logic port2_indicator_lo_i,
	output logic port2_indicator_lo_o,
	output logic port2_indicator_lo_oe_o,
	// Port status and indicator function select
	input wire shs_pkg::shs_port_status_t port1_status_i,
	input wire shs_pkg::shs_port_status_t port2_status_i,
	input wire logic [1:0] led_mode_i,
	// Strap results
	output logic strap_valid_o,
	output logic port1_autoneg_en_o,
	output logic port1_force_100_o,
	output logic port1_force_10_o,
	output shs_pkg::shs_access_mode_t access_mode_o,
	output logic management_serial_mode_o,
	// EEPROM load results
	output logic [7:0] cfg_byte_o,
	output logic [7:0] cfg_index_o,
	output logic cfg_valid_o,
	output logic cfg_done_o,
	output logic cfg_use_defaults_o
);

	localparam int QW = $clog2(QTR_CYC + 1);
	localparam logic [QW-1:0] QTR_LOAD = QW'(QTR_CYC - 1);
	localparam logic [7:0] SEQ_LAST = 8'(shs_pkg::SEQ_FIRST_DATA + CFG_BYTES - 1);

	typedef enum logic [2:0] {
		I_IDLE = 3'b000,
		I_START = 3'b001,
		I_BIT = 3'b010,
		I_STOP = 3'b011,
		I_DONE = 3'b100
	} shs_i2c_state_t;

	logic sel_lvl;
	logic sda_lvl;
	logic [3:0] ind_lvl;
	shs_pkg::shs_strap_t strap_q;
	logic strap_valid_q;
	logic sel_prev_q;
	logic start_q;
	logic sdo_q;
	logic [3:0] ind_q;
	logic mode_i2c;
	logic mode_spi;
	shs_pkg::shs_access_mode_t mode;

	shs_pin_sync #(
		.WIDTH(6)
	) u_sync (
		.clk_sys_i(clk_sys_i),
		.pin_i({serial_select_n_i, sda_i, port1_indicator_hi_i, port1_indicator_lo_i,
			port2_indicator_hi_i, port2_indicator_lo_i}),
		.level_o({sel_lvl, sda_lvl, ind_lvl})
	);

	// Picks the two indicator levels; indicators are active low.
	function automatic logic [1:0] led_pair(input logic [1:0] sel,
		input shs_pkg::shs_port_status_t st);
		logic link_act_n;
		link_act_n = !st.link || st.activity;
		case (sel)
			2'h0: led_pair = {!st.speed_100, link_act_n};
			2'h1: led_pair = {!st.full_duplex, link_act_n};
			2'h2: led_pair = {!st.full_duplex, !st.link};
			default: led_pair = {!st.speed_100, !st.link};
		endcase
	endfunction : led_pair

	// The first clocked cycle after release still sees reset-time pin levels, since the
	// pins stay undriven until this capture is done.
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			strap_valid_q <= 1'b0;
			strap_q <= '0;
		end else if (!strap_valid_q) begin
			strap_valid_q <= 1'b1; // see [RL12]
			strap_q <= ind_lvl; // see [RL12]
		end
	end

	assign mode = shs_pkg::shs_access_mode_t'({strap_q.p2_hi, strap_q.p2_lo}); // see [RL6]
	assign mode_i2c = strap_valid_q && (mode == shs_pkg::SHS_MODE_I2C_HOST); // see [RL6]
	assign mode_spi = strap_valid_q && (mode == shs_pkg::SHS_MODE_SPI_CLIENT); // see [RL10]

	assign strap_valid_o = strap_valid_q;
	assign access_mode_o = mode;
	assign management_serial_mode_o = strap_valid_q && (mode == shs_pkg::SHS_MODE_MGMT); // see [RL11]
	assign port1_autoneg_en_o = strap_q.p1_autoneg; // see [RL4]
	assign port1_force_100_o = strap_valid_q && !strap_q.p1_autoneg && strap_q.p1_speed; // see [RL3]
	assign port1_force_10_o = strap_valid_q && !strap_q.p1_autoneg && !strap_q.p1_speed; // see [RL3]

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			sel_prev_q <= 1'b1;
			start_q <= 1'b0;
		end else begin
			sel_prev_q <= sel_lvl;
			start_q <= mode_spi && sel_prev_q && !sel_lvl; // see [RL2]
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			sdo_q <= 1'b0;
		end else begin
			sdo_q <= serial_client_data_i;
		end
	end

	assign transfer_start_o = start_q;
	assign serial_client_out_o = sdo_q;
	assign serial_client_out_oe_o = mode_spi && !sel_lvl; // see [RL1] [RL8]

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			ind_q <= '1;
		end else begin
			ind_q <= {led_pair(led_mode_i, port1_status_i), led_pair(led_mode_i, port2_status_i)}; // see [RL5]
		end
	end

	assign {port1_indicator_hi_o, port1_indicator_lo_o} = ind_q[3:2];
	assign {port2_indicator_hi_o, port2_indicator_lo_o} = ind_q[1:0];
	assign port1_indicator_hi_oe_o = strap_valid_q; // see [RL12]
	assign port1_indicator_lo_oe_o = strap_valid_q;
	assign port2_indicator_hi_oe_o = strap_valid_q;
	assign port2_indicator_lo_oe_o = strap_valid_q;

	// EEPROM loader: each bit takes four quarter ticks of the host clock.
	shs_i2c_state_t st_q;
	logic [QW-1:0] qcnt_q;
	logic [1:0] phase_q;
	logic [3:0] bit_q;
	logic [7:0] byte_q;
	logic [8:0] sh_q;
	logic scl_q;
	logic sda_low_q;
	logic nack_q;
	logic done_q;
	logic defaults_q;
	logic [7:0] cfg_byte_q;
	logic [7:0] cfg_index_q;
	logic cfg_valid_q;
	logic tick;
	logic is_read;

	// Bits that are ones leave the line released, so read bytes shift in the EEPROM data.
	function automatic logic [8:0] load_byte(input logic [7:0] idx);
		if (idx == shs_pkg::SEQ_CTRL_WR) begin
			load_byte = {shs_pkg::I2C_CTRL_WR, 1'b1}; // see [RL9]
		end else if (idx == shs_pkg::SEQ_ADDR) begin
			load_byte = {shs_pkg::EEPROM_START_ADDR, 1'b1};
		end else if (idx == shs_pkg::SEQ_CTRL_RD) begin
			load_byte = {shs_pkg::I2C_CTRL_RD, 1'b1}; // see [RL9]
		end else begin
			load_byte = {8'hFF, idx == SEQ_LAST};
		end
	endfunction : load_byte

	assign tick = (qcnt_q == '0);
	assign is_read = (byte_q >= shs_pkg::SEQ_FIRST_DATA);

	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !mode_i2c || tick) begin
			qcnt_q <= QTR_LOAD;
		end else begin
			qcnt_q <= qcnt_q - QW'(1);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			st_q <= I_IDLE;
			phase_q <= 2'h0;
			bit_q <= 4'h0;
			byte_q <= 8'h00;
			sh_q <= '1;
			scl_q <= 1'b1;
			sda_low_q <= 1'b0;
			nack_q <= 1'b0;
			done_q <= 1'b0;
			defaults_q <= 1'b0;
		end else if (mode_i2c && tick) begin
			phase_q <= phase_q + 2'h1;
			case (st_q)
				I_IDLE: begin
					st_q <= I_START;
					phase_q <= 2'h0;
					sh_q <= load_byte(byte_q);
				end
				I_START: begin
					case (phase_q)
						2'h0: sda_low_q <= 1'b0;
						2'h1: scl_q <= 1'b1;
						2'h2: sda_low_q <= 1'b1;
						default: begin
							scl_q <= 1'b0;
							st_q <= I_BIT;
							bit_q <= shs_pkg::I2C_LAST_BIT;
						end
					endcase
				end
				I_BIT: begin
					case (phase_q)
						2'h0: sda_low_q <= !sh_q[8];
						2'h1: scl_q <= 1'b1;
						2'h2: begin
							sh_q <= {sh_q[7:0], sda_lvl};
							if (bit_q == 4'h0 && !is_read && sda_lvl) begin
								nack_q <= 1'b1; // see [RL7]
							end
						end
						default: begin
							scl_q <= 1'b0;
							bit_q <= bit_q - 4'h1;
							if (bit_q == 4'h0) begin
								byte_q <= byte_q + 8'h01;
								sh_q <= load_byte(byte_q + 8'h01);
								if (nack_q || byte_q == SEQ_LAST) begin
									st_q <= I_STOP;
								end else if (byte_q == shs_pkg::SEQ_ADDR) begin
									st_q <= I_START;
								end else begin
									bit_q <= shs_pkg::I2C_LAST_BIT;
								end
							end
						end
					endcase
				end
				I_STOP: begin
					case (phase_q)
						2'h0: sda_low_q <= 1'b1;
						2'h1: scl_q <= 1'b1;
						2'h2: sda_low_q <= 1'b0;
						default: begin
							st_q <= I_DONE;
							done_q <= 1'b1;
							defaults_q <= nack_q; // see [RL7]
						end
					endcase
				end
				default: phase_q <= 2'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			cfg_valid_q <= 1'b0;
			cfg_byte_q <= 8'h00;
			cfg_index_q <= 8'h00;
		end else begin
			cfg_valid_q <= mode_i2c && tick && st_q == I_BIT && phase_q == 2'h2
				&& bit_q == 4'h0 && is_read;
			if (mode_i2c && tick && st_q == I_BIT && phase_q == 2'h2 && bit_q == 4'h0) begin
				cfg_byte_q <= sh_q[7:0];
				cfg_index_q <= byte_q - shs_pkg::SEQ_FIRST_DATA;
			end
		end
	end

	assign scl_o = scl_q;
	assign scl_oe_o = mode_i2c; // see [RL8]
	assign sda_o = 1'b0;
	assign sda_oe_o = mode_i2c && sda_low_q; // see [RL8]
	assign cfg_byte_o = cfg_byte_q;
	assign cfg_index_o = cfg_index_q;
	assign cfg_valid_o = cfg_valid_q;
	assign cfg_done_o = done_q;
	assign cfg_use_defaults_o = defaults_q;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (srst_i);

	sequence s_select_fall;
		mode_spi && sel_prev_q && !sel_lvl;
	endsequence
	sequence s_ctrl_wr_nack;
		mode_i2c && tick && st_q == I_BIT && phase_q == 2'h2 && bit_q == 4'h0
			&& byte_q == shs_pkg::SEQ_CTRL_WR && sda_lvl;
	endsequence

	a_deselect_float: assert property (sel_lvl |-> !serial_client_out_oe_o) // see [RL1]
		else $error("serial output driven while deselected");
	a_select_start: assert property (s_select_fall |=> transfer_start_o ##1 !transfer_start_o) // see [RL2]
		else $error("no single start pulse after select fall");
	a_force_speed: assert property (strap_valid_q && !strap_q.p1_autoneg |-> // see [RL3]
		port1_force_100_o == strap_q.p1_speed && port1_force_10_o == !strap_q.p1_speed)
		else $error("forced speed does not follow strap");
	a_autoneg_strap: assert property ($rose(strap_valid_q) |-> // see [RL4]
		port1_autoneg_en_o == $past(ind_lvl[2]))
		else $error("autoneg enable differs from sampled strap");
	a_led_default: assert property (led_mode_i == 2'h0 ##1 strap_valid_q |-> // see [RL5]
		port1_indicator_hi_o == !$past(port1_status_i.speed_100))
		else $error("first indicator does not show speed");
	a_host_mode: assert property (strap_valid_q && !strap_q.p2_hi && !strap_q.p2_lo |-> // see [RL6]
		access_mode_o == shs_pkg::SHS_MODE_I2C_HOST && scl_oe_o)
		else $error("straps 00 did not select host mode");
	a_absent_fallback: assert property (s_ctrl_wr_nack |-> ##[1:200] st_q == I_STOP) // see [RL7]
		else $error("missing eeprom did not end the load");
	a_defaults_flag: assert property ($rose(cfg_done_o) |-> cfg_use_defaults_o == $past(nack_q)) // see [RL7]
		else $error("defaults flag does not match eeprom answer");
	a_host_pins: assert property (mode_i2c |-> scl_oe_o && !serial_client_out_oe_o // see [RL8]
		&& !transfer_start_o && !sda_o)
		else $error("host mode pin use wrong");
	a_ctrl_bytes: assert property (st_q == I_START && phase_q == 2'h3 && tick |-> // see [RL9]
		sh_q[8:1] == (byte_q == shs_pkg::SEQ_CTRL_WR ? 8'hBE : 8'hBF))
		else $error("wrong control byte after start");
	a_strap_input: assert property (!strap_valid_q |-> !port1_indicator_hi_oe_o // see [RL12]
		&& !port1_indicator_lo_oe_o && !port2_indicator_hi_oe_o && !port2_indicator_lo_oe_o)
		else $error("strap pin driven before capture");

endmodule : shs_strap_select

//--- tb/shs_eeprom_model.sv
// Behavioural configuration memory on a two-wire bus, answering the block's loader.
// Assumes the data line is open drain and that the bench resolves both lines with pull-ups.
module shs_eeprom_model #(
	parameter logic [7:0] BASE = 8'hC5
) (
	// Bus lines
	input wire logic scl_i,
	input wire logic sda_i,
	// Memory fitted or not
	input wire logic present_i,
	// High while the model pulls the data line low
	output logic pull_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] sh;
	logic [7:0] data;
	logic act = 1'b0;
	logic first = 1'b0;
	logic rd_go = 1'b0;
	logic pend_rd = 1'b0;
	int bitn = 0;
	int ptr = 0;
	initial pull_o = 1'b0;
	// Start and stop are only seen while the clock line is high.
	always @(negedge sda_i) begin
		if (scl_i === 1'b1) begin
			act = 1'b1;
			first = 1'b1;
			rd_go = 1'b0;
			pend_rd = 1'b0;
			bitn = 0;
		end
	end
	always @(posedge sda_i) begin
		if (scl_i === 1'b1) begin
			act = 1'b0;
		end
	end
	// A high level in the loader's acknowledge slot ends the read burst.
	always @(posedge scl_i) begin
		if (act) begin
			if (bitn < 8) begin
				sh = {sh[6:0], sda_i};
			end else if (rd_go && sda_i) begin
				rd_go = 1'b0;
			end
			bitn++;
		end
	end
	// The model only ever changes its pull on the data line while the clock line is low.
	always @(negedge scl_i) begin
		if (act) begin
			if (bitn == 9) begin
				bitn = 0;
				first = 1'b0;
				if (rd_go) begin
					ptr++;
				end
				rd_go = rd_go | pend_rd;
				pend_rd = 1'b0;
			end
			if (bitn == 8) begin
				pull_o = !rd_go && present_i && (!first || sh == 8'hBE || sh == 8'hBF);
				pend_rd = pull_o && first && sh == 8'hBF;
				if (pull_o && !first) begin
					ptr = int'(sh);
				end
			end else begin
				data = BASE + 8'(ptr);
				pull_o = rd_go && !data[7 - bitn];
			end
		end
	end
endmodule : shs_eeprom_model

//--- tb/shs_strap_select_tb.sv
// Self-checking bench for the strap and serial host bus select block.
// Assumes the package, the design and the memory model are compiled before it.
module shs_strap_select_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int NB = 2;
	// First byte of the model's memory; the model counts up from here.
	localparam logic [7:0] MEM_BASE = 8'hC5;
	logic clk_sys_i, srst_i, sel_n, sdata, present;
	logic [3:0] strap, ind_i;
	wire [3:0] ind_o, ind_oe;
	logic [1:0] m, lm;
	shs_pkg::shs_port_status_t st1, st2;
	shs_pkg::shs_access_mode_t mode;
	logic so, so_oe, tstart, scl, scl_oe, sda_o, sda_oe, pull, sda_w, scl_w;
	logic valid, aneg, f100, f10, mgmt, cvalid, cdone, cdef;
	logic [7:0] cbyte, cidx;
	int error_cnt = 0;
	int compares = 0;
	int starts = 0;
	int nvalid = 0;
	// Strap pins read the bench's level until the block turns them into outputs.
	assign ind_i = (ind_oe & ind_o) | (~ind_oe & strap);
	assign sda_w = ~((sda_oe & ~sda_o) | pull);
	assign scl_w = scl_oe ? scl : 1'b1;
	shs_strap_select #(.CFG_BYTES(NB), .QTR_CYC(4)) u_shs_strap_select (
		.clk_sys_i(clk_sys_i), .srst_i(srst_i),
		.serial_select_n_i(sel_n), .serial_client_data_i(sdata),
		.serial_client_out_o(so), .serial_client_out_oe_o(so_oe), .transfer_start_o(tstart),
		.scl_o(scl), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.port1_indicator_hi_i(ind_i[3]), .port1_indicator_hi_o(ind_o[3]),
		.port1_indicator_hi_oe_o(ind_oe[3]), .port1_indicator_lo_i(ind_i[2]),
		.port1_indicator_lo_o(ind_o[2]), .port1_indicator_lo_oe_o(ind_oe[2]),
		.port2_indicator_hi_i(ind_i[1]), .port2_indicator_hi_o(ind_o[1]),
		.port2_indicator_hi_oe_o(ind_oe[1]), .port2_indicator_lo_i(ind_i[0]),
		.port2_indicator_lo_o(ind_o[0]), .port2_indicator_lo_oe_o(ind_oe[0]),
		.port1_status_i(st1), .port2_status_i(st2), .led_mode_i(lm),
		.strap_valid_o(valid), .port1_autoneg_en_o(aneg), .port1_force_100_o(f100),
		.port1_force_10_o(f10), .access_mode_o(mode), .management_serial_mode_o(mgmt),
		.cfg_byte_o(cbyte), .cfg_index_o(cidx), .cfg_valid_o(cvalid),
		.cfg_done_o(cdone), .cfg_use_defaults_o(cdef)
	);
	shs_eeprom_model #(.BASE(MEM_BASE)) u_shs_eeprom_model (
		.scl_i(scl_w), .sda_i(sda_w), .present_i(present), .pull_o(pull)
	);
	initial begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	always @(posedge clk_sys_i) begin
		if (tstart === 1'b1) begin
			starts++;
		end
		if (cvalid === 1'b1) begin
			check("cfg_index", cidx, 8'(nvalid));
			check("cfg_byte", cbyte, MEM_BASE + 8'(nvalid));
			nvalid++;
		end
	end
	task automatic do_reset(input logic [3:0] s);
		srst_i = 1'b1;
		strap = s;
		nvalid = 0;
		repeat (6) @(negedge clk_sys_i);
		check("oe_in_reset", ind_oe, 8'h00);
		srst_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		check("strap_valid", valid, 8'h01);
		check("ind_oe", ind_oe, 8'h0F);
	endtask : do_reset
	task automatic sel_cycle(input logic e_oe, input int e_st);
		starts = 0;
		sdata = 1'b1;
		sel_n = 1'b0;
		repeat (8) @(negedge clk_sys_i);
		check("out_oe_selected", so_oe, e_oe);
		if (e_oe) begin
			check("out_data", so, 8'h01);
		end
		sel_n = 1'b1;
		sdata = 1'b0;
		repeat (8) @(negedge clk_sys_i);
		check("out_oe_deselected", so_oe, 8'h00);
		check("start_count", 8'(starts), 8'(e_st));
	endtask : sel_cycle
	task automatic wait_load(input logic e_def, input int e_n);
		int k;
		k = 0;
		while (cdone !== 1'b1 && k < 5000) begin
			@(negedge clk_sys_i);
			k++;
		end
		check("cfg_done", cdone, 8'h01);
		check("use_defaults", cdef, e_def);
		check("cfg_count", 8'(nvalid), 8'(e_n));
	endtask : wait_load
	initial begin
		srst_i = 1'b1;
		sel_n = 1'b1;
		sdata = 1'b0;
		present = 1'b1;
		st1 = 4'h0;
		st2 = 4'h0;
		strap = 4'h0;
		m = 2'h0;
		lm = 2'h0;
		@(negedge clk_sys_i);
		// Every access mode, with the port 1 straps walked alongside.
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			do_reset({m[0], m[1], m});
			check("mode", mode, m);
			check("mgmt", mgmt, m == 2'h3);
			check("autoneg", aneg, m[1]);
			check("force_100", f100, !m[1] && m[0]);
			check("force_10", f10, !m[1] && !m[0]);
			check("scl_oe", scl_oe, m == 2'h0);
			sel_cycle(m == 2'h2, (m == 2'h2) ? 1 : 0);
			if (m == 2'h0) begin
				wait_load(1'b0, NB);
			end else begin
				check("no_load", cdone, 8'h00);
			end
		end
		// No memory answers, so the loader must give up and keep defaults.
		present = 1'b0;
		do_reset(4'h0);
		wait_load(1'b1, 0);
		st1 = 4'hA;
		repeat (4) @(negedge clk_sys_i);
		check("led_speed_on", ind_o[3], 8'h00);
		check("led_link_on", ind_o[2], 8'h00);
		check("led_port2_off", ind_o[1:0], 8'h03);
		st1 = 4'h0;
		st2 = 4'hA;
		repeat (4) @(negedge clk_sys_i);
		check("led_speed_off", ind_o[3], 8'h01);
		check("led_link_off", ind_o[2], 8'h01);
		check("led_port2_on", ind_o[1:0], 8'h00);
		// Another function select: duplex on the first lamp, plain link on the second.
		lm = 2'h2;
		st1 = 4'hA;
		repeat (4) @(negedge clk_sys_i);
		check("led_alt_port1", ind_o[3:2], 8'h02);
		check("led_alt_port2", ind_o[1:0], 8'h02);
		stop_test();
	end
	initial begin
		#(20 * 40000);
		error_cnt++;
		stop_test();
	end
endmodule : shs_strap_select_tb
